/* File: verilog/hbuf_pkg.sv */
// Purpose: Constants and carriers for the host buffer RAM control registers.
// Assumes: Command-code register access over a 16-bit microprocessor port.
// Notes: Notes on the behaviour follow.
package hbuf_pkg;
  localparam logic [7:0] CMD_ISO_LEN_RD = 8'h2a;
  localparam logic [7:0] CMD_ISO_LEN_WR = 8'haa;
  localparam logic [7:0] CMD_ACK_LEN_RD = 8'h2b;
  localparam logic [7:0] CMD_ACK_LEN_WR = 8'hab;
  localparam logic [7:0] CMD_STATUS_RD = 8'h2c;
  localparam logic [7:0] CMD_SOFT_RESET_WR = 8'ha9;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h00f6;
  localparam logic [15:0] LEN_RESET = 16'h0000;
  localparam logic [15:0] RAM_BYTES = 16'h1000;
  localparam int ST_ISO0_FULL = 0;
  localparam int ST_ISO1_FULL = 1;
  localparam int ST_ACK_FULL = 2;
  localparam int ST_ISO0_DONE = 3;
  localparam int ST_ISO1_DONE = 4;
  localparam int ST_ACK_DONE = 5;

  // Region index, matching the bit order of the engine event fields
  typedef enum logic [1:0] {REG_ISO0, REG_ISO1, REG_ACK} region_e;

  // One microprocessor register access
  typedef struct packed {
    logic cmd_valid;
    logic [7:0] cmd;
    logic wr_valid;
    logic [15:0] wr_data;
  } cpu_req_s;

  // Per-region events from the list engine, one bit per region
  typedef struct packed {
    logic [2:0] filled;
    logic [2:0] emptied;
    logic [2:0] consumed;
    logic [2:0] rearmed;
  } engine_evt_s;

  // Region map handed to the list engine
  typedef struct packed {
    logic [15:0] ack_base;
    logic [15:0] ack_len;
    logic [15:0] iso0_base;
    logic [15:0] iso1_base;
    logic [15:0] iso_len;
    logic fits;
  } region_map_s;
endpackage : hbuf_pkg

/* File: verilog/host_buffer_ram_control.sv */
// Purpose: Buffer length, status and soft reset registers of the host controller.
// Assumes: Command then data word on the same clock; engine events are same-clock.
// Notes: Soft reset is a registered pulse also offered to the rest of the controller.
`timescale 1ns/1ns
module host_buffer_ram_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Microprocessor register port
  input hbuf_pkg::cpu_req_s cpu_req,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // List engine side
  input hbuf_pkg::engine_evt_s engine_evt,
  output hbuf_pkg::region_map_s region_map,
  output logic soft_reset_pulse
);
  import hbuf_pkg::*;

  // All module state
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] iso_len;
    logic [15:0] ack_len;
    logic [5:0] status;
    logic [15:0] rd_data;
    logic rd_valid;
    logic soft_rst;
    region_map_s map;
  } state_s;

  state_s state_reg; // Registered state
  state_s state_next; // Next state

  // Sticky flag update, set wins over clear
  function automatic logic [2:0] sticky(input logic [2:0] cur, input logic [2:0] set,
                                        input logic [2:0] clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // Next state
  always_comb
  begin
    logic [16:0] total;
    total = 17'h0;
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.soft_rst = 1'b0;
    // Latch the command code
    if (cpu_req.cmd_valid)
    begin
      state_next.cmd = cpu_req.cmd;
    end
    // Data write for the latched command
    if (cpu_req.wr_valid)
    begin
      unique case (state_reg.cmd)
        CMD_ISO_LEN_WR: state_next.iso_len = cpu_req.wr_data;
        CMD_ACK_LEN_WR: state_next.ack_len = cpu_req.wr_data;
        CMD_SOFT_RESET_WR:
        begin
          // Only the key value triggers; no read path exists
          if (cpu_req.wr_data == SOFT_RESET_KEY)
          begin
            state_next.soft_rst = 1'b1;
          end
        end
        default: ; // Other codes belong elsewhere
      endcase
    end
    // Data read for the latched command
    if (rd_strobe)
    begin
      state_next.rd_valid = 1'b1;
      unique case (state_reg.cmd)
        CMD_ISO_LEN_RD: state_next.rd_data = state_reg.iso_len;
        CMD_ACK_LEN_RD: state_next.rd_data = state_reg.ack_len;
        CMD_STATUS_RD: state_next.rd_data = {10'h000, state_reg.status};
        default: state_next.rd_data = 16'h0000;
      endcase
    end
    // Full flags per region
    state_next.status[ST_ACK_FULL:ST_ISO0_FULL] =
      sticky(state_reg.status[ST_ACK_FULL:ST_ISO0_FULL], engine_evt.filled,
             engine_evt.emptied);
    // Consumed flags per region
    state_next.status[ST_ACK_DONE:ST_ISO0_DONE] =
      sticky(state_reg.status[ST_ACK_DONE:ST_ISO0_DONE], engine_evt.consumed,
             engine_evt.rearmed);
    // Region layout: ack first, then iso0, then iso1
    state_next.map.ack_base = 16'h0000;
    state_next.map.ack_len = state_next.ack_len;
    state_next.map.iso0_base = state_next.ack_len;
    state_next.map.iso1_base = 16'(state_next.ack_len + state_next.iso_len);
    state_next.map.iso_len = state_next.iso_len;
    // Flag a layout that software left oversized
    total = {1'b0, state_next.ack_len} + {state_next.iso_len, 1'b0};
    state_next.map.fits = (total <= {1'b0, RAM_BYTES}) && !state_next.iso_len[15];
    // Soft reset returns registers to reset values, RAM untouched
    if (state_reg.soft_rst)
    begin
      state_next = '0;
      state_next.map.fits = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
      state_reg.map.fits <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
  assign region_map = state_reg.map;
  assign soft_reset_pulse = state_reg.soft_rst;
endmodule : host_buffer_ram_control

/* File: verif/engine_model.sv */
// Purpose: List engine stand-in
// Assumes: One event per go
// Notes: Events last one cycle
`timescale 1ns/1ns
module engine_model (
  // Bench request and events out
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [4:0] what,
  output hbuf_pkg::engine_evt_s engine_evt
);
  // Kind 3 fills, 2 empties, 1 consumes, 0 rearms
  always_ff @(posedge clk_sys)
    engine_evt <= go ? ({9'h0, what[2:0]} << (3 * what[4:3])) : '0;
endmodule : engine_model

/* File: verif/host_buffer_ram_control_assertions.sv */
// Purpose: Port checks
// Assumes: Command precedes data
// Notes: c_reg shadows the command
`timescale 1ns/1ns
module host_buffer_ram_control_assertions (
  input wire logic clk_sys,
  input wire logic reset_n,
  input hbuf_pkg::cpu_req_s cpu_req,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input hbuf_pkg::region_map_s region_map,
  input wire logic soft_reset_pulse
);
  logic [7:0] c_reg;  // Latched command
  wire w = cpu_req.wr_valid;  // Write strobe
  wire [15:0] d = cpu_req.wr_data, al = region_map.ack_len, il = region_map.iso_len;
  // Command shadow
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) c_reg <= '0;
    else if (soft_reset_pulse) c_reg <= '0;  // Soft reset drops the latched command too
    else if (cpu_req.cmd_valid) c_reg <= cpu_req.cmd;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_key_pulse: assert property (w && c_reg == 8'ha9 && d == 16'hf6 |=> soft_reset_pulse)
    else $error("pulse");
  chk_soft_clear: assert property (soft_reset_pulse |=> al == 0 && il == 0) else $error("c");
  chk_iso_write: assert property (w && c_reg == 8'haa |=> il == $past(d)) else $error("iso");
  chk_ack_write: assert property (w && c_reg == 8'hab |=> al == $past(d)) else $error("ack");
  chk_iso_bases: assert property (region_map.iso0_base == al && region_map.iso1_base == al + il)
    else $error("layout");
  chk_fits_flag: assert property (region_map.fits == ({2'b0, al} + {1'b0, il, 1'b0} <= 18'h1000))
    else $error("fits");
  chk_status_spare: assert property (rd_valid && $past(c_reg) == 8'h2c |-> rd_data[15:6] == 0)
    else $error("spare");
  chk_wo_read: assert property (rd_valid && $past(c_reg) == 8'ha9 |-> rd_data == 0) else $error("r");
endmodule : host_buffer_ram_control_assertions
bind host_buffer_ram_control host_buffer_ram_control_assertions asrt_i (.clk_sys, .reset_n,
  .cpu_req, .rd_valid, .rd_data, .region_map, .soft_reset_pulse);

/* File: verif/host_buffer_ram_control_tb_top.sv */
// Purpose: Bench for the buffer control registers
// Assumes: Command, then one word
// Notes: Seeded lengths and events
`timescale 1ns/1ns
module host_buffer_ram_control_tb_top;
  import hbuf_pkg::*;
  logic clk_sys = 0, reset_n = 0, rd_strobe = 0, go = 0, rd_valid, soft_reset_pulse;
  logic [4:0] ks = 0;  // Event kind and regions
  logic [5:0] st = 0;  // Expected status
  logic [15:0] rd_data, a, b;
  cpu_req_s req = '0;
  engine_evt_s evt;
  region_map_s map;  // Region layout seen by the engine
  int n_mismatch, check_count, cyc, seed = 32'h0721;
  host_buffer_ram_control host_buffer_ram_control_i (.clk_sys, .reset_n, .cpu_req(req),
    .rd_strobe, .rd_data, .rd_valid, .engine_evt(evt), .region_map(map), .soft_reset_pulse);
  engine_model engine_model_i (.clk_sys, .go, .what(ks), .engine_evt(evt));
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (++cyc == 2000) close_out(1);
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) $display("mismatch %0t got %h", $time, got);
    n_mismatch += (got !== exp);
  endtask : chk
  task automatic close_out(input int late);
    n_mismatch += late;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // Command, then a write, or a read checked against d
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge clk_sys) req <= '{1'b1, c, 1'b0, d};
    @(posedge clk_sys) req <= '{1'b0, c, w, d};
    rd_strobe <= !w;
    @(posedge clk_sys) {req.wr_valid, rd_strobe} <= 2'b00;
    #1 if (!w) chk(rd_valid ? rd_data : ~d, d);
  endtask : xfer
  // Status after one event: fill and consume set flags, empty and rearm clear them
  function automatic logic [5:0] upd(input logic [4:0] k, input logic [5:0] t);
    return k[3] ? t | (k[4] ? {3'b0, k[2:0]} : {k[2:0], 3'b0}) : t & ~{k[2:0], k[2:0]} | t & (k[4] ? 6'h38 : 6'h07);
  endfunction : upd
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1;
    for (int i = 0; i < 5; i++) xfer(i < 4 ? 8'h2a + 8'(i) : 8'ha9, 0, 0);
    for (int i = 0; i < 8; i++)
    begin
      a = i ? 16'($random(seed) >> 19) : 16'h0800;
      b = i ? 16'($random(seed) >> 20) : 16'h0400;
      xfer(8'haa, 1, b);
      xfer(8'hab, 1, a);
      xfer(8'h2a, 0, b);
      xfer(8'h2b, 0, a);
      chk(map.iso0_base, a);
      chk(map.iso1_base, 16'(a + b));
      chk({15'h0, map.fits}, {15'h0, (17'(a) + 17'(b) * 17'd2) <= 17'h1000});
    end
    xfer(8'h2c, 1, 16'hffff);
    $display("test lengths done");
    repeat (16)
    begin
      @(posedge clk_sys) {ks, go} <= {5'($random(seed)), 1'b1};
      @(posedge clk_sys) go <= 0;
      st = upd(ks, st);
      xfer(8'h2c, 0, {10'h0, st});
    end
    $display("test status done");
    xfer(8'ha9, 1, 16'h01f6);
    xfer(8'h2b, 0, a);
    xfer(8'ha9, 1, SOFT_RESET_KEY);
    chk({15'h0, soft_reset_pulse}, 16'h0001);
    for (int i = 0; i < 5; i++) xfer(i < 4 ? 8'h2a + 8'(i) : 8'ha9, 0, 0);
    $display("test soft reset done");
    close_out(0);
  end
endmodule : host_buffer_ram_control_tb_top
